// file: rtl/lcs_map.svh
// Offsets, field positions, reset values and timing counts of the charge sequencer.
// Assumes a 10 MHz pclk; included by its bare name.
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define LCS_CLK_HZ       10000000
`define LCS_TICK_MS      125
`define LCS_TICK_CYC     (`LCS_CLK_HZ / 1000 * `LCS_TICK_MS)
`define LCS_SEC_MS       1000
`define LCS_SEC_TICKS    (`LCS_SEC_MS / `LCS_TICK_MS)
`define LCS_BLINK_MS     625
`define LCS_BLINK_TICKS  (`LCS_BLINK_MS / `LCS_TICK_MS)
`define LCS_HOUR_S       3600
`define LCS_HOUR_TICKS   (`LCS_HOUR_S * `LCS_SEC_TICKS)
`define LCS_DEB_CYC      4

// ----------------------------------------
// Registers
// ----------------------------------------
`define LCS_CTRL_OFS     12'h000
`define LCS_STAT_OFS     12'h004
`define LCS_CTRL_RST     32'h0000_0001
`define LCS_CTRL_MASK    32'h0000_0001
`define LCS_CTRL_ALLOW   0

`endif

// file: rtl/lcs_pkg.sv
// Types of the charge sequencer: states and grouped signals.
// Assumes nothing beyond a SystemVerilog compiler.
package lcs_pkg;

    typedef enum logic [6:0] {
        LCS_STANDBY = 7'h01,
        LCS_FAST    = 7'h02,
        LCS_PAUSE   = 7'h04,
        LCS_DEFECT  = 7'h08,
        LCS_TOPOFF  = 7'h10,
        LCS_MONITOR = 7'h20,
        LCS_FAULT   = 7'h40
    } lcs_state_e;

    // Comparator outputs, all active high
    typedef struct packed {
        logic ov;          // battery above over-voltage threshold
        logic oc;          // sense voltage above 1V
        logic eoc;         // sense voltage fallen to 40 mV
        logic rfv_ok;      // resistance-free voltage above 3.65V
        logic below_float; // battery down to float level
        logic at_term;     // battery at termination level
        logic above_cond;  // battery above 2.55V
    } lcs_cmp_s;

    // Regulation control towards the analog loops
    typedef struct packed {
        logic level_hi;  // high voltage select: 4.2V/4.09V/4.4V set
        logic cc_mode;   // constant current, 0.5V sense limit
        logic cv_mode;   // constant voltage at termination level
        logic float_sel; // target dropped to float level
    } lcs_reg_s;

endpackage

// file: rtl/lcs_top.sv
// Charge-mode sequencer with APB status and control registers.
// Assumes asynchronous comparator and pin inputs, open-drain indicator pads outside.
//
// What this block does
// - Battery above 2.55V enters fast charge
// - Fast charge: first indicator low, second released
// - Below termination level: constant current selected
// - At termination level: constant voltage selected
// - End of charge: gate off one second
// - Low resistance-free voltage: suspend, blink first
// - Good voltage: top-off, second indicator low
// - Top-off one hour, then monitor
// - Monitor drops target to float level
// - Self-discharge to float restarts fast charge
// - Refresh repeats until pack removed or CTRL allow bit cleared
// - Over-voltage enters fault, gate off
// - Over-current enters fault, gate off
// - Fault blinks both indicators together
// - Fault latched until pack removed or CTRL allow bit cleared
// - Voltage select picks level set
// - Standby: gate off, indicators released
`timescale 1ns/1ns
`default_nettype none
`include "lcs_map.svh"

module lcs_top #(
    parameter int unsigned TICK_CYC   = `LCS_TICK_CYC,
    parameter int unsigned HOUR_TICKS = `LCS_HOUR_TICKS,
    parameter int unsigned DEB_CYC    = `LCS_DEB_CYC
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire lcs_pkg::lcs_cmp_s cmp_in,
    input  wire logic             pack_present,
    input  wire logic             voltage_select,
    input  wire logic             first_indicator_in,
    output logic                  first_indicator_out,
    output logic                  first_indicator_oe,
    input  wire logic             second_indicator_in,
    output logic                  second_indicator_out,
    output logic                  second_indicator_oe,
    output logic                  pass_gate_drive,
    output lcs_pkg::lcs_reg_s     reg_ctl
);

    localparam int NIN = 11;

    // ----------------------------------------
    // Input synchronisers and debounce
    // ----------------------------------------
    logic [NIN-1:0]     raw;
    logic [NIN-1:0]     flt;
    lcs_pkg::lcs_cmp_s  c;
    logic               en;
    logic [31:0]        ctrl;

    assign raw = {second_indicator_in, first_indicator_in, voltage_select, pack_present, cmp_in};
    assign c   = flt[6:0];
    assign en  = flt[7] & ctrl[`LCS_CTRL_ALLOW];

    for (genvar gi = 0; gi < NIN; gi++) begin : g_in
        logic [2:0] sh;
        logic [3:0] cnt;
        logic [3:0] next_cnt;
        logic       f;
        logic       next_f;
        always_comb begin
            next_cnt = 4'h0;
            next_f   = f;
            // A glitch shorter than the debounce window never reaches the sequencer
            if (sh[2] == sh[1] && sh[2] != f) begin
                if (cnt == 4'(DEB_CYC - 1)) begin
                    next_f = sh[2];
                end else begin
                    next_cnt = cnt + 4'h1;
                end
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sh  <= 3'h0;
                cnt <= 4'h0;
                f   <= 1'b0;
            end else begin
                sh  <= {sh[1:0], raw[gi]};
                cnt <= next_cnt;
                f   <= next_f;
            end
        end
        assign flt[gi] = f;
    end

    // ----------------------------------------
    // Free-running prescaler
    // ----------------------------------------
    logic [20:0] pre;
    logic [20:0] next_pre;
    logic        tick;
    logic        next_tick;

    always_comb begin
        next_tick = 1'b0;
        next_pre  = pre + 21'h1;
        if (pre == 21'(TICK_CYC - 1)) begin
            next_pre  = 21'h0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre  <= 21'h0;
            tick <= 1'b0;
        end else begin
            pre  <= next_pre;
            tick <= next_tick;
        end
    end

    // ----------------------------------------
    // Sequencer, state timer and blink phase
    // ----------------------------------------
    lcs_pkg::lcs_state_e state;
    lcs_pkg::lcs_state_e next_state;
    logic [14:0]         tmr;
    logic [14:0]         next_tmr;
    logic [2:0]          bcnt;
    logic [2:0]          next_bcnt;
    logic                phase;
    logic                next_phase;

    always_comb begin
        next_state = state;
        case (state)
            lcs_pkg::LCS_STANDBY: begin
                if (c.above_cond) next_state = lcs_pkg::LCS_FAST;
            end
            lcs_pkg::LCS_FAST: begin
                if (c.eoc) next_state = lcs_pkg::LCS_PAUSE;
            end
            lcs_pkg::LCS_PAUSE: begin
                if (tick && tmr == 15'(`LCS_SEC_TICKS - 1)) begin
                    next_state = c.rfv_ok ? lcs_pkg::LCS_TOPOFF : lcs_pkg::LCS_DEFECT;
                end
            end
            lcs_pkg::LCS_TOPOFF: begin
                if (tick && tmr == 15'(HOUR_TICKS - 1)) next_state = lcs_pkg::LCS_MONITOR;
            end
            lcs_pkg::LCS_MONITOR: begin
                if (c.below_float) next_state = lcs_pkg::LCS_FAST;
            end
            default: begin
                next_state = state;
            end
        endcase
        // Pack removal or a cleared CTRL allow bit beats everything; fault is only left that way
        if (!en) begin
            next_state = lcs_pkg::LCS_STANDBY;
        end else if (c.ov || c.oc) begin
            next_state = lcs_pkg::LCS_FAULT;
        end
        // Timers restart at every state entry, so a period may end up to one tick early
        next_tmr   = tmr;
        next_bcnt  = bcnt;
        next_phase = phase;
        if (next_state != state) begin
            next_tmr   = 15'h0;
            next_bcnt  = 3'h0;
            next_phase = 1'b1;
        end else if (tick) begin
            next_tmr = tmr + 15'h1;
            if (bcnt == 3'(`LCS_BLINK_TICKS - 1)) begin
                next_bcnt  = 3'h0;
                next_phase = ~phase;
            end else begin
                next_bcnt = bcnt + 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= lcs_pkg::LCS_STANDBY;
            tmr   <= 15'h0;
            bcnt  <= 3'h0;
            phase <= 1'b1;
        end else begin
            state <= next_state;
            tmr   <= next_tmr;
            bcnt  <= next_bcnt;
            phase <= next_phase;
        end
    end

    // ----------------------------------------
    // Pin and regulation outputs
    // ----------------------------------------
    logic              next_pgd;
    logic              next_oe1;
    logic              next_oe2;
    lcs_pkg::lcs_reg_s next_reg;

    always_comb begin
        next_pgd = 1'b0;
        next_oe1 = 1'b0;
        next_oe2 = 1'b0;
        case (next_state)
            lcs_pkg::LCS_FAST: begin
                next_pgd = 1'b1;
                next_oe1 = 1'b1;
            end
            lcs_pkg::LCS_PAUSE: begin
                next_oe1 = 1'b1;
            end
            lcs_pkg::LCS_DEFECT: begin
                next_oe1 = next_phase;
            end
            lcs_pkg::LCS_TOPOFF: begin
                next_pgd = 1'b1;
                next_oe2 = 1'b1;
            end
            lcs_pkg::LCS_MONITOR: begin
                next_oe2 = 1'b1;
            end
            lcs_pkg::LCS_FAULT: begin
                next_oe1 = next_phase;
                next_oe2 = next_phase;
            end
            default: begin
                next_pgd = 1'b0;
            end
        endcase
        next_reg.level_hi  = flt[8];
        next_reg.cc_mode   = next_state == lcs_pkg::LCS_FAST && !c.at_term;
        next_reg.cv_mode   = next_state == lcs_pkg::LCS_FAST && c.at_term;
        next_reg.float_sel = next_state == lcs_pkg::LCS_MONITOR;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pass_gate_drive      <= 1'b0;
            first_indicator_oe   <= 1'b0;
            second_indicator_oe  <= 1'b0;
            first_indicator_out  <= 1'b0;
            second_indicator_out <= 1'b0;
            reg_ctl              <= '0;
        end else begin
            pass_gate_drive      <= next_pgd;
            first_indicator_oe   <= next_oe1;
            second_indicator_oe  <= next_oe2;
            first_indicator_out  <= 1'b0;
            second_indicator_out <= 1'b0;
            reg_ctl              <= next_reg;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    logic [31:0] status;
    logic [31:0] next_ctrl;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    assign status = {13'h0, pass_gate_drive, flt, state};

    always_comb begin
        next_ctrl    = ctrl;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        // Answer decoded at setup, so the access phase always ends in one cycle
        if (psel && !penable) begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            if (paddr == `LCS_CTRL_OFS) begin
                if (!pwrite) next_prdata = ctrl;
            end else if (paddr == `LCS_STAT_OFS) begin
                if (!pwrite) next_prdata = status;
            end else begin
                next_pslverr = 1'b1;
            end
        end
        if (psel && penable && pready && pwrite && paddr == `LCS_CTRL_OFS) begin
            next_ctrl = pwdata & `LCS_CTRL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= `LCS_CTRL_RST;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    enter_fast_a: assert property (state == lcs_pkg::LCS_STANDBY && en && c.above_cond && !c.ov && !c.oc |=> state == lcs_pkg::LCS_FAST) else $error("no fast charge entry");
    fast_pins_a: assert property (state == lcs_pkg::LCS_FAST |-> pass_gate_drive && first_indicator_oe && !second_indicator_oe) else $error("bad fast charge pins");
    cc_select_a: assert property (state == lcs_pkg::LCS_FAST && $past(state) == lcs_pkg::LCS_FAST && !$past(c.at_term) |-> reg_ctl.cc_mode && !reg_ctl.cv_mode) else $error("cc not selected");
    cv_select_a: assert property (state == lcs_pkg::LCS_FAST && $past(state) == lcs_pkg::LCS_FAST && $past(c.at_term) |-> reg_ctl.cv_mode && !reg_ctl.cc_mode) else $error("cv not selected");
    eoc_pause_a: assert property (state == lcs_pkg::LCS_FAST && c.eoc && en && !c.ov && !c.oc |=> state == lcs_pkg::LCS_PAUSE && !pass_gate_drive) else $error("no pause on end of charge");
    pause_hold_a: assert property (state == lcs_pkg::LCS_PAUSE && en && !c.ov && !c.oc && !(tick && tmr == 15'(`LCS_SEC_TICKS - 1)) |=> state == lcs_pkg::LCS_PAUSE && !pass_gate_drive) else $error("pause ended early");
    rfv_low_a: assert property (state == lcs_pkg::LCS_PAUSE && tick && tmr == 15'(`LCS_SEC_TICKS - 1) && !c.rfv_ok && en && !c.ov && !c.oc |=> state == lcs_pkg::LCS_DEFECT ##0 !pass_gate_drive && !second_indicator_oe) else $error("defect not flagged");
    topoff_pins_a: assert property (state == lcs_pkg::LCS_TOPOFF |-> pass_gate_drive && !first_indicator_oe && second_indicator_oe) else $error("bad top-off pins");
    hour_end_a: assert property (state == lcs_pkg::LCS_TOPOFF && tick && tmr == 15'(HOUR_TICKS - 1) && en && !c.ov && !c.oc |=> state == lcs_pkg::LCS_MONITOR ##0 !pass_gate_drive) else $error("top-off did not end");
    monitor_float_a: assert property (state == lcs_pkg::LCS_MONITOR |-> reg_ctl.float_sel && !pass_gate_drive) else $error("monitor target wrong");
    refresh_a: assert property (state == lcs_pkg::LCS_MONITOR && c.below_float && en && !c.ov && !c.oc |=> state == lcs_pkg::LCS_FAST) else $error("no refresh");
    fault_entry_a: assert property (en && (c.ov || c.oc) |=> state == lcs_pkg::LCS_FAULT && !pass_gate_drive) else $error("fault missed");
    fault_blink_a: assert property (state == lcs_pkg::LCS_FAULT |-> first_indicator_oe == second_indicator_oe) else $error("indicators not together");
    fault_latch_a: assert property (state == lcs_pkg::LCS_FAULT && en |=> state == lcs_pkg::LCS_FAULT) else $error("fault not latched");
    level_sel_a: assert property (reg_ctl.level_hi == $past(flt[8])) else $error("level set not following select");
    standby_pins_a: assert property (state == lcs_pkg::LCS_STANDBY |-> !pass_gate_drive && !first_indicator_oe && !second_indicator_oe) else $error("standby pins driven");

    topoff_c: cover property (state == lcs_pkg::LCS_PAUSE ##1 state == lcs_pkg::LCS_TOPOFF);
    refresh_c: cover property (state == lcs_pkg::LCS_MONITOR ##1 state == lcs_pkg::LCS_FAST);
    fault_c: cover property (state == lcs_pkg::LCS_FAULT ##1 state == lcs_pkg::LCS_STANDBY);
    defect_c: cover property (state == lcs_pkg::LCS_PAUSE ##1 state == lcs_pkg::LCS_DEFECT);

endmodule

`default_nettype wire

// file: bench/lcs_partner.sv
// Comparator and pad model on the analog side of the charge sequencer.
// Assumes the bench sets battery, sense and resistance-free voltages in mV.
`timescale 1ns/1ns
`default_nettype none

module lcs_partner (
    input  wire logic         voltage_select,
    input  var  int           vbat_mv,
    input  var  int           sense_mv,
    input  var  int           rfv_mv,
    input  wire logic         first_oe,
    input  wire logic         first_out,
    input  wire logic         second_oe,
    input  wire logic         second_out,
    output lcs_pkg::lcs_cmp_s cmp_in,
    output logic              first_pad,
    output logic              second_pad
);
    int term;
    int flt;
    int ovt;

    // ----------------------------------------
    // Comparators
    // ----------------------------------------
    always_comb begin
        term = voltage_select ? 4200 : 4100;
        flt = voltage_select ? 4090 : 3840;
        ovt = voltage_select ? 4400 : 4300;
        cmp_in.above_cond = vbat_mv > 2550;
        cmp_in.at_term = vbat_mv >= term;
        cmp_in.below_float = vbat_mv <= flt;
        cmp_in.ov = vbat_mv > ovt;
        cmp_in.oc = sense_mv > 1000;
        cmp_in.eoc = sense_mv <= 40;
        cmp_in.rfv_ok = rfv_mv > 3650;
    end

    // ----------------------------------------
    // Pads
    // ----------------------------------------
    // Pull-up on the board: a released pad reads high
    assign first_pad = first_oe ? first_out : 1'b1;
    assign second_pad = second_oe ? second_out : 1'b1;
endmodule

`default_nettype wire

// file: bench/tb.sv
// Self-checking bench of the charge sequencer: APB status reads, pin timing.
// Assumes lcs_top with short tick and hour counts, and lcs_partner beside it.
`timescale 1ns/1ns
`default_nettype none

module tb;
    localparam int TICK = 10;
    localparam logic [6:0] S_SB = 7'h01, S_FC = 7'h02, S_PA = 7'h04, S_DF = 7'h08;
    localparam logic [6:0] S_TO = 7'h10, S_MO = 7'h20, S_FT = 7'h40;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
        logic [3:0]  ctl;
        logic [3:0]  cmask;
    } lcs_note_s;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, lfsr;
    logic pack_present, voltage_select, p1_pad, p2_pad, p1_out, p1_oe, p2_out, p2_oe;
    logic pass_gate_drive;
    lcs_pkg::lcs_cmp_s cmp_in;
    lcs_pkg::lcs_reg_s reg_ctl;
    int vbat_mv, sense_mv, rfv_mv, fail_count, num_checks, n;
    lcs_note_s notes[$];
    lcs_note_s note;
    time t0;

    lcs_top #(.TICK_CYC(TICK), .HOUR_TICKS(4), .DEB_CYC(4)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_in(cmp_in), .pack_present(pack_present),
        .voltage_select(voltage_select), .first_indicator_in(p1_pad),
        .first_indicator_out(p1_out), .first_indicator_oe(p1_oe),
        .second_indicator_in(p2_pad), .second_indicator_out(p2_out),
        .second_indicator_oe(p2_oe), .pass_gate_drive(pass_gate_drive), .reg_ctl(reg_ctl));

    lcs_partner u_far (
        .voltage_select(voltage_select), .vbat_mv(vbat_mv), .sense_mv(sense_mv),
        .rfv_mv(rfv_mv), .first_oe(p1_oe), .first_out(p1_out), .second_oe(p2_oe),
        .second_out(p2_out), .cmp_in(cmp_in), .first_pad(p1_pad), .second_pad(p2_pad));

    always #50 pclk = ~pclk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic int rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return int'(lfsr[15:0]);
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input lcs_note_s nt);
        int k;
        k = 0;
        notes.push_back(nt);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            fail_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected STATUS and regulation outputs follow from the state, pack_present, voltage_select and the cc and cv arguments
    task automatic status(input logic [6:0] st, input logic cc, input logic cv);
        lcs_note_s nt;
        nt.data = {13'h0, st inside {S_FC, S_TO}, !(st inside {S_TO, S_MO}),
                   !(st inside {S_FC, S_PA}), voltage_select, pack_present, 7'h0, st};
        // Blinking pins are timed separately
        nt.mask = (st inside {S_DF, S_FT}) ? 32'h0004_C07F : 32'h0007_C07F;
        nt.err = 1'b0;
        nt.ctl = {voltage_select, cc, cv, st == S_MO};
        nt.cmask = (st == S_FC) ? 4'hF : 4'h9;
        apb(1'b0, 12'h004, 32'h0, nt);
    endtask

    task automatic set_v(input int v, input int s, input int r);
        @(posedge pclk);
        vbat_mv <= v;
        sense_mv <= s;
        rfv_mv <= r;
        // Covers input filter, state change and the filtered pad readback
        repeat (20) @(posedge pclk);
    endtask

    task automatic wait_pgd(input logic lvl, output int k);
        k = 0;
        while (pass_gate_drive !== lvl && k < 1000) begin
            @(negedge pclk);
            k++;
        end
        check("pgd_wait", 32'(k < 1000), 32'h1);
    endtask

    task automatic blink(output int k);
        logic v;
        int j;
        v = p1_oe;
        j = 0;
        while (p1_oe === v && j < 200) begin
            @(negedge pclk);
            j++;
        end
        v = p1_oe;
        k = 0;
        while (p1_oe === v && k < 200) begin
            @(negedge pclk);
            k++;
        end
    endtask

    // ----------------------------------------
    // Result monitor
    // ----------------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            check("prdata", prdata & note.mask, note.data & note.mask);
            check("pslverr", {31'h0, pslverr}, {31'h0, note.err});
            check("reg_ctl", {28'h0, reg_ctl & note.cmask}, {28'h0, note.ctl & note.cmask});
        end
    end

    initial begin
        #(100 * 30000);
        fail_count++;
        wrap_up();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        pack_present = 0; voltage_select = 0; vbat_mv = 0; sense_mv = 500; rfv_mv = 3700;
        lfsr = 79770;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, '{32'h1, '1, 1'b0, 4'h0, 4'h0});
        apb(1'b0, 12'h008, 32'h0, '{32'h0, '1, 1'b1, 4'h0, 4'h0});
        status(S_SB, 0, 0);
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            pack_present <= 1'b0;
            voltage_select <= i[0] ^ lfsr[0];
            set_v(1000 + rnd() % 1500, 500, 3700);
            status(S_SB, 0, 0);
            @(posedge pclk);
            pack_present <= 1'b1;
            set_v(2600 + rnd() % 1400, 500, 3700);
            status(S_FC, 1, 0);
            for (int j = 0; j < 2; j++) begin
                set_v(voltage_select ? 4200 : 4100, 500, 3651 + rnd() % 500);
                status(S_FC, 0, 1);
                @(posedge pclk);
                sense_mv <= 40;
                wait_pgd(1'b0, n);
                wait_pgd(1'b1, n);
                check("pause_len", 32'(n > 7 * TICK && n <= 8 * TICK), 32'h1);
                t0 = $time;
                // Pad readback lags the pins by the input filter
                repeat (12) @(posedge pclk);
                status(S_TO, 0, 0);
                wait_pgd(1'b0, n);
                n = int'(($time - t0) / 100);
                check("topoff_len", 32'(n > 3 * TICK && n <= 4 * TICK), 32'h1);
                status(S_MO, 0, 0);
                set_v(voltage_select ? 4090 : 3840, 500, 3700);
                status(S_FC, 1, 0);
            end
        end
        set_v(vbat_mv, 40, 3650 - rnd() % 500);
        repeat (90) @(posedge pclk);
        status(S_DF, 0, 0);
        blink(n);
        check("defect_blink", n, 5 * TICK);
        for (int f = 0; f < 2; f++) begin
            @(posedge pclk);
            pack_present <= 1'b0;
            set_v(3000, 500, 3700);
            status(S_SB, 0, 0);
            @(posedge pclk);
            pack_present <= 1'b1;
            set_v(3000, 500, 3700);
            status(S_FC, 1, 0);
            if (f == 0)
                set_v((voltage_select ? 4401 : 4301) + rnd() % 90, 500, 3700);
            else
                set_v(3000, 1001 + rnd() % 500, 3700);
            status(S_FT, 0, 0);
            blink(n);
            check("fault_blink", n, 5 * TICK);
            check("fault_pair", {31'h0, p2_oe}, {31'h0, p1_oe});
            set_v(3000, 500, 3700);
            status(S_FT, 0, 0);
        end
        @(posedge pclk);
        pack_present <= 1'b0;
        repeat (12) @(posedge pclk);
        pack_present <= 1'b1;
        repeat (12) @(posedge pclk);
        apb(1'b1, 12'h000, 32'h0, '{32'h0, '1, 1'b0, 4'h0, 4'h0});
        repeat (12) @(posedge pclk);
        status(S_SB, 0, 0);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF, '{32'h0, '1, 1'b0, 4'h0, 4'h0});
        apb(1'b1, 12'h000, 32'h1, '{32'h0, '1, 1'b0, 4'h0, 4'h0});
        repeat (12) @(posedge pclk);
        pack_present <= 1'b0;
        repeat (2) @(posedge pclk);
        pack_present <= 1'b1;
        repeat (12) @(posedge pclk);
        status(S_FC, 1, 0);
        wrap_up();
    end
endmodule

`default_nettype wire
